/* File: rtl/imc_fifo.sv */
// small synchronous FIFO with valid/ready on both sides
// assumes one clock; a push into a full FIFO is refused by inReady
module imc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtrQ;
    logic [AW-1:0] rdPtrQ;
    logic [AW:0] countQ;
    logic push;
    logic pop;

    assign inReady = (countQ != (AW+1)'(DEPTH));
    assign outValid = (countQ != '0);
    assign outData = mem[rdPtrQ];
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtrQ] <= inData;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            wrPtrQ <= '0;
            rdPtrQ <= '0;
            countQ <= '0;
        end else begin
            if (push) begin
                wrPtrQ <= (wrPtrQ == AW'(DEPTH - 1)) ? '0 : wrPtrQ + 1'b1;
            end
            if (pop) begin
                rdPtrQ <= (rdPtrQ == AW'(DEPTH - 1)) ? '0 : rdPtrQ + 1'b1;
            end
            if (push && !pop) begin
                countQ <= countQ + 1'b1;
            end else if (pop && !push) begin
                countQ <= countQ - 1'b1;
            end
        end
    end
endmodule : imc_fifo

/* File: rtl/imc_mode_ctrl.sv */
// bus mode register and frame engine of a two-wire serial interface unit
// assumes open-drain pins resolved outside; register port read data one cycle late

module imc_mode_ctrl (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOen,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOen,
    output logic txReady,
    output logic eventFlag,
    output logic busy
);
    logic rstMetaQ;
    logic rstN;

    // release of the asynchronous reset through two flops
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rstMetaQ <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMetaQ <= 1'b1;
            rstN <= rstMetaQ;
        end
    end

    imc_pkg::imc_mode_t modeQ;
    imc_pkg::imc_state_t stateQ;
    logic enableQ;
    logic masterQ;
    logic transmitQ;
    logic flagQ;
    logic fmtPriQ;
    logic fmtSecQ;
    logic rangeQ;
    logic [7:0] rxByteQ;
    logic [7:0] txShQ;
    logic [7:0] rxShQ;
    logic [8:0] cntQ;
    logic [3:0] bitIdxQ;
    logic sclLevel;
    logic sdaLevel;
    logic sclPrevQ;
    logic sdaPrevQ;

    imc_sync3 u_sclSync (
        .clk(clk_sys),
        .rstN(rstN),
        .pinIn(sclIn),
        .level(sclLevel)
    );

    imc_sync3 u_sdaSync (
        .clk(clk_sys),
        .rstN(rstN),
        .pinIn(sdaIn),
        .level(sdaLevel)
    );

    // register port decode
    logic wrMode;
    logic wrCtrl;
    logic wrFmt;
    logic wrData;
    assign wrMode = regWrite && regAddr == imc_pkg::ADDR_MODE && enableQ;
    assign wrCtrl = regWrite && regAddr == imc_pkg::ADDR_CTRL;
    assign wrFmt = regWrite && regAddr == imc_pkg::ADDR_FMT;
    assign wrData = regWrite && regAddr == imc_pkg::ADDR_DATA;

    // format and frame geometry
    logic syncFmt;
    logic [3:0] totalBits;
    logic [3:0] dataBits;
    logic waitEff;
    logic [8:0] halfLimit;
    assign syncFmt = fmtPriQ & fmtSecQ;
    always_comb begin
        if (syncFmt) begin
            // no acknowledge bit in the synchronous format
            totalBits = (modeQ.frameCount == 3'h0) ? imc_pkg::SYNC_FULL_BITS
                                                   : {1'b0, modeQ.frameCount};
            dataBits = totalBits;
        end else begin
            totalBits = (modeQ.frameCount == 3'h0) ? imc_pkg::BUS_FULL_BITS
                                                   : {1'b0, modeQ.frameCount} + 4'h1;
            dataBits = totalBits - 4'h1;
        end
    end
    assign waitEff = modeQ.waitInsert & masterQ & ~syncFmt;
    // half a serial clock period, divisor only used by the master engine
    assign halfLimit = (imc_pkg::divisor(rangeQ, modeQ.clkSel) >> 1) - 9'h001;

    // bus event detection on filtered pins
    logic startDet;
    logic sclRise;
    assign startDet = sclLevel & sclPrevQ & sdaPrevQ & ~sdaLevel;
    assign sclRise = sclLevel & ~sclPrevQ;

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            sclPrevQ <= 1'b1;
            sdaPrevQ <= 1'b1;
        end else begin
            sclPrevQ <= sclLevel;
            sdaPrevQ <= sdaLevel;
        end
    end

    // transmit FIFO: every master frame consumes one word, receive frames ignore its value
    logic fifoValid;
    logic fifoPop;
    logic fifoInReady;
    logic [7:0] fifoData;
    imc_fifo #(
        .WIDTH(imc_pkg::TX_WIDTH),
        .DEPTH(imc_pkg::TX_DEPTH)
    ) u_txFifo (
        .clk(clk_sys),
        .rstN(rstN),
        .inValid(wrData),
        .inReady(fifoInReady),
        .inData(regWrData),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData(fifoData)
    );

    logic masterGo;
    logic slaveOn;
    assign masterGo = enableQ & masterQ;
    assign slaveOn = enableQ & ~masterQ & ~syncFmt;
    assign fifoPop = (stateQ == imc_pkg::ST_IDLE) & masterGo & fifoValid;

    // outgoing data bit for a given bit index, with data already shifted
    function automatic logic sdaRelease(input logic [3:0] idx, input logic [7:0] sh);
        logic r;
        r = 1'b1;
        if (idx < dataBits) begin
            // short frames leave transmit data at the end named by bit order
            r = transmitQ ? (modeQ.bitOrder ? sh[0] : sh[7]) : 1'b1;
        end else begin
            // acknowledge: receiver pulls low, transmitter listens
            r = transmitQ;
        end
        return r;
    endfunction : sdaRelease

    logic frameEnd;
    logic waitEnter;
    logic [3:0] nextIdx;
    logic [7:0] txShifted;
    logic [7:0] rxShifted;
    assign nextIdx = bitIdxQ + 4'h1;
    assign txShifted = modeQ.bitOrder ? {1'b0, txShQ[7:1]} : {txShQ[6:0], 1'b0};
    // receive fills from the low end for MSB first, from the high end for LSB first
    assign rxShifted = modeQ.bitOrder ? {sdaLevel, rxShQ[7:1]} : {rxShQ[6:0], sdaLevel};

    logic highDone;
    assign highDone = (stateQ == imc_pkg::ST_HIGH) && cntQ == halfLimit;
    assign waitEnter = highDone && nextIdx == dataBits && waitEff;
    assign frameEnd = (highDone && nextIdx == totalBits)
                    || (slaveOn && sclRise && nextIdx == totalBits);

    // master frame engine and slave bit counting
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            stateQ <= imc_pkg::ST_IDLE;
            cntQ <= 9'h000;
            bitIdxQ <= 4'h0;
            txShQ <= imc_pkg::DATA_RESET;
            rxShQ <= imc_pkg::DATA_RESET;
            sclOen <= 1'b1;
            sdaOen <= 1'b1;
        end else if (!enableQ) begin
            stateQ <= imc_pkg::ST_IDLE;
            cntQ <= 9'h000;
            bitIdxQ <= 4'h0;
            sclOen <= 1'b1;
            sdaOen <= 1'b1;
        end else begin
            case (stateQ)
                imc_pkg::ST_IDLE: begin
                    cntQ <= 9'h000;
                    if (fifoPop) begin
                        txShQ <= fifoData;
                        bitIdxQ <= 4'h0;
                        sclOen <= 1'b0;
                        sdaOen <= sdaRelease(4'h0, fifoData);
                        stateQ <= imc_pkg::ST_LOW;
                    end else if (slaveOn) begin
                        // slave takes its clock from the bus, no divider involved
                        if (startDet) begin
                            bitIdxQ <= 4'h0;
                        end else if (sclRise) begin
                            if (bitIdxQ < dataBits) begin
                                rxShQ <= rxShifted;
                            end
                            bitIdxQ <= (nextIdx == totalBits) ? 4'h0 : nextIdx;
                        end
                    end
                end
                imc_pkg::ST_LOW: begin
                    if (cntQ == halfLimit) begin
                        cntQ <= 9'h000;
                        sclOen <= 1'b1;
                        stateQ <= imc_pkg::ST_HIGH;
                    end else begin
                        cntQ <= cntQ + 9'h001;
                    end
                end
                imc_pkg::ST_HIGH: begin
                    if (cntQ == halfLimit) begin
                        cntQ <= 9'h000;
                        if (bitIdxQ < dataBits) begin
                            rxShQ <= rxShifted;
                            txShQ <= txShifted;
                        end
                        if (frameEnd) begin
                            bitIdxQ <= 4'h0;
                            sdaOen <= 1'b1;
                            stateQ <= imc_pkg::ST_IDLE;
                        end else if (waitEnter) begin
                            // clock held low until software clears the flag
                            bitIdxQ <= nextIdx;
                            sclOen <= 1'b0;
                            sdaOen <= 1'b1;
                            stateQ <= imc_pkg::ST_WAIT;
                        end else begin
                            // no pause before the acknowledge clock
                            bitIdxQ <= nextIdx;
                            sclOen <= 1'b0;
                            sdaOen <= sdaRelease(nextIdx, txShifted);
                            stateQ <= imc_pkg::ST_LOW;
                        end
                    end else begin
                        cntQ <= cntQ + 9'h001;
                    end
                end
                imc_pkg::ST_WAIT: begin
                    cntQ <= 9'h000;
                    if (!flagQ) begin
                        sdaOen <= sdaRelease(bitIdxQ, txShQ);
                        stateQ <= imc_pkg::ST_LOW;
                    end
                end
                default: begin
                    stateQ <= imc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // received byte latched at the end of each frame
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            rxByteQ <= imc_pkg::DATA_RESET;
        end else if (frameEnd) begin
            rxByteQ <= (bitIdxQ < dataBits) ? rxShifted : rxShQ;
        end
    end

    // mode register; hardware clear of the bit count beats a software write
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            modeQ <= imc_pkg::MODE_RESET;
        end else begin
            if (wrMode) begin
                modeQ <= regWrData;
            end
            if (frameEnd || (startDet && enableQ)) begin
                modeQ.frameCount <= 3'h0;
            end
        end
    end

    // control and format registers
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            enableQ <= imc_pkg::CTRL_RESET[imc_pkg::CTRL_ENABLE];
            masterQ <= imc_pkg::CTRL_RESET[imc_pkg::CTRL_MASTER];
            transmitQ <= imc_pkg::CTRL_RESET[imc_pkg::CTRL_TRANSMIT];
            fmtPriQ <= imc_pkg::FMT_RESET[imc_pkg::FMT_PRIMARY];
            fmtSecQ <= imc_pkg::FMT_RESET[imc_pkg::FMT_SECONDARY];
            rangeQ <= imc_pkg::FMT_RESET[imc_pkg::FMT_RANGE];
        end else begin
            if (wrCtrl) begin
                enableQ <= regWrData[imc_pkg::CTRL_ENABLE];
                masterQ <= regWrData[imc_pkg::CTRL_MASTER];
                transmitQ <= regWrData[imc_pkg::CTRL_TRANSMIT];
            end
            if (wrFmt) begin
                fmtPriQ <= regWrData[imc_pkg::FMT_PRIMARY];
                fmtSecQ <= regWrData[imc_pkg::FMT_SECONDARY];
                rangeQ <= regWrData[imc_pkg::FMT_RANGE];
            end
        end
    end

    // transfer event flag: set wins over a same-cycle software clear
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            flagQ <= imc_pkg::CTRL_RESET[imc_pkg::CTRL_EVENT];
        end else if (frameEnd || waitEnter) begin
            flagQ <= 1'b1;
        end else if (wrCtrl && !regWrData[imc_pkg::CTRL_EVENT]) begin
            flagQ <= 1'b0;
        end
    end

    // read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            regRdData <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                imc_pkg::ADDR_MODE: regRdData <= enableQ ? modeQ : 8'h00;
                imc_pkg::ADDR_CTRL: regRdData <= {enableQ, 1'b0, masterQ, transmitQ,
                                                  3'b000, flagQ};
                imc_pkg::ADDR_FMT: regRdData <= {5'b00000, rangeQ, fmtSecQ, fmtPriQ};
                imc_pkg::ADDR_DATA: regRdData <= rxByteQ;
                imc_pkg::ADDR_STAT: regRdData <= {4'h0, ~fifoValid, ~fifoInReady,
                                                  stateQ == imc_pkg::ST_WAIT,
                                                  stateQ != imc_pkg::ST_IDLE};
                default: regRdData <= 8'h00;
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end

    // registered copies for txReady, eventFlag and busy; sclOut and sdaOut held low
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            sclOut <= 1'b0;
            sdaOut <= 1'b0;
            txReady <= 1'b0;
            eventFlag <= 1'b0;
            busy <= 1'b0;
        end else begin
            sclOut <= 1'b0;
            sdaOut <= 1'b0;
            txReady <= fifoInReady;
            eventFlag <= flagQ;
            busy <= stateQ != imc_pkg::ST_IDLE;
        end
    end
endmodule : imc_mode_ctrl

/* File: rtl/imc_pkg.sv */
// constants, register map and field layout of the bus mode control block
// assumes an 8-bit register port and a 40 MHz system clock
package imc_pkg;

    // register indices on the plain register port
    localparam logic [2:0] ADDR_MODE = 3'h0;
    localparam logic [2:0] ADDR_CTRL = 3'h1;
    localparam logic [2:0] ADDR_FMT = 3'h2;
    localparam logic [2:0] ADDR_DATA = 3'h3;
    localparam logic [2:0] ADDR_STAT = 3'h4;

    // control register field positions
    localparam int CTRL_ENABLE = 7;
    localparam int CTRL_MASTER = 5;
    localparam int CTRL_TRANSMIT = 4;
    localparam int CTRL_EVENT = 0;

    // format register field positions
    localparam int FMT_PRIMARY = 0;
    localparam int FMT_SECONDARY = 1;
    localparam int FMT_RANGE = 2;

    // status register field positions
    localparam int STAT_BUSY = 0;
    localparam int STAT_WAITING = 1;
    localparam int STAT_TXFULL = 2;
    localparam int STAT_TXEMPTY = 3;

    // values after reset
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] FMT_RESET = 8'h02;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // bits per frame for a zero bit count code
    localparam logic [3:0] BUS_FULL_BITS = 4'h9;
    localparam logic [3:0] SYNC_FULL_BITS = 4'h8;

    // transmit FIFO shape
    localparam int TX_WIDTH = 8;
    localparam int TX_DEPTH = 4;

    // system clock rate
    localparam int CLK_HZ = 40_000_000;

    typedef struct packed {
        logic bitOrder;
        logic waitInsert;
        logic [2:0] clkSel;
        logic [2:0] frameCount;
    } imc_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOW = 2'b01,
        ST_HIGH = 2'b11,
        ST_WAIT = 2'b10
    } imc_state_t;

    // serial clock divisor for clock select and rate range, in system clocks
    function automatic logic [8:0] divisor(input logic range, input logic [2:0] sel);
        logic [8:0] d;
        d = 9'h01C;
        case ({range, sel})
            4'h0: d = 9'h01C;
            4'h1: d = 9'h028;
            4'h2: d = 9'h030;
            4'h3: d = 9'h040;
            4'h4: d = 9'h050;
            4'h5: d = 9'h064;
            4'h6: d = 9'h070;
            4'h7: d = 9'h080;
            4'h8: d = 9'h038;
            4'h9: d = 9'h050;
            4'hA: d = 9'h060;
            4'hB: d = 9'h080;
            4'hC: d = 9'h0A0;
            4'hD: d = 9'h0C8;
            4'hE: d = 9'h0E0;
            default: d = 9'h100;
        endcase
        return d;
    endfunction : divisor

endpackage : imc_pkg

/* File: rtl/imc_sync3.sv */
// three-stage synchroniser with agreement filter for one pin input
// assumes the pin idles high; output changes when stages two and three agree
module imc_sync3 (
    input wire logic clk,
    input wire logic rstN,
    input wire logic pinIn,
    output logic level
);
    logic s1Q;
    logic s2Q;
    logic s3Q;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            s1Q <= 1'b1;
            s2Q <= 1'b1;
            s3Q <= 1'b1;
        end else begin
            s1Q <= pinIn;
            s2Q <= s1Q;
            s3Q <= s2Q;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            level <= 1'b1;
        end else if (s2Q == s3Q) begin
            level <= s3Q;
        end
    end
endmodule : imc_sync3

/* File: sim/imc_bus_partner.sv */
// receiving slave on the two-wire bus; resolves both open-drain lines
// assumes pull-ups on both lines; clr clears the rise and bit counters (not perCnt) and stretches SCL low
module imc_bus_partner (
    input wire logic clk_sys,
    input wire logic clr,
    input wire logic sclOen,
    input wire logic sdaOen,
    output logic sclLine,
    output logic sdaLine,
    output logic [7:0] rxByte,
    output logic [7:0] riseCnt,
    output logic [15:0] maxPer
);
    timeunit 1ns;
    timeprecision 100ps;
    logic sclPrev = 1'b1;
    logic ackPull = 1'b0;
    logic [3:0] bitN = 4'h0;
    logic [15:0] perCnt = 16'h0000;
    // stretches the clock only while clr is high, so a slow answer shows only as a late ack
    assign sclLine = sclOen & ~clr;
    assign sdaLine = sdaOen & ~ackPull;
    always @(posedge clk_sys) begin
        sclPrev <= sclLine;
        perCnt <= perCnt + 16'h0001;
        if (clr) begin
            sclPrev <= 1'b1;
            rxByte <= 8'h00;
            riseCnt <= 8'h00;
            bitN <= 4'h0;
            maxPer <= 16'h0000;
            ackPull <= 1'b0;
        end else if (sclLine && !sclPrev) begin
            riseCnt <= riseCnt + 8'h01;
            bitN <= (bitN == 4'h8) ? 4'h0 : bitN + 4'h1;
            if (bitN < 4'h8) rxByte <= {rxByte[6:0], sdaLine};
            if (riseCnt != 8'h00 && perCnt > maxPer) maxPer <= perCnt;
            perCnt <= 16'h0001;
        end else if (!sclLine && sclPrev) begin
            ackPull <= (bitN == 4'h8);
        end
    end
endmodule : imc_bus_partner

/* File: sim/imc_mode_ctrl_props.sv */
// assertions on the register port and pins of the bus mode control block
// assumes it is bound into imc_mode_ctrl and sees only its ports
module imc_mode_ctrl_props (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdData,
    input wire logic sclOut,
    input wire logic sclOen,
    input wire logic sdaOut,
    input wire logic sdaOen
);
    // serial clock half periods, indexed by {range, clock select}
    localparam int HALF [16] = '{14, 20, 24, 32, 40, 50, 56, 64, 28, 40, 48, 64, 80, 100, 112, 128};
    logic enQ;
    logic masterQ;
    logic [4:0] modeQ;
    logic [2:0] fmtQ;
    logic [8:0] lowCnt;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    // shadow of software writes; bit count left out as hardware clears it
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            enQ <= 1'b0;
            masterQ <= 1'b0;
            modeQ <= 5'h00;
            fmtQ <= imc_pkg::FMT_RESET[2:0];
        end else if (regWrite) begin
            if (regAddr == imc_pkg::ADDR_CTRL) begin
                enQ <= regWrData[7];
                masterQ <= regWrData[5];
            end
            if (regAddr == imc_pkg::ADDR_MODE && enQ) begin
                modeQ <= regWrData[7:3];
            end
            if (regAddr == imc_pkg::ADDR_FMT) begin
                fmtQ <= regWrData[2:0];
            end
        end
    end
    // saturating so a long wait state cannot wrap
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            lowCnt <= 9'h000;
        end else if (sclOen) begin
            lowCnt <= 9'h000;
        end else if (lowCnt != 9'h1FF) begin
            lowCnt <= lowCnt + 9'h001;
        end
    end
    a_read_quiet: assert property (!$past(regRead) |-> regRdData == 8'h00)
        else $error("read data not zero outside read slot");
    a_mode_locked: assert property (
        regRead && regAddr == imc_pkg::ADDR_MODE && !enQ |=> regRdData == 8'h00)
        else $error("mode register readable while disabled");
    a_mode_value: assert property (
        regRead && regAddr == imc_pkg::ADDR_MODE && enQ |=> regRdData[7:3] == modeQ)
        else $error("mode register read mismatch");
    a_ctrl_enable: assert property (
        regRead && regAddr == imc_pkg::ADDR_CTRL |=> regRdData[7] == enQ)
        else $error("enable bit read mismatch");
    a_fmt_value: assert property (
        regRead && regAddr == imc_pkg::ADDR_FMT |=> regRdData[2:0] == fmtQ)
        else $error("format register read mismatch");
    a_pins_open: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
        else $error("open drain output value not low");
    a_abort_release: assert property ($fell(enQ) |-> ##[1:3] (sclOen && sdaOen))
        else $error("pins not released after disable");
    a_low_phase: assert property (
        $rose(sclOen) && enQ && masterQ |-> lowCnt >= HALF[{fmtQ[2], modeQ[2:0]}])
        else $error("serial clock low phase too short");
endmodule : imc_mode_ctrl_props

bind imc_mode_ctrl imc_mode_ctrl_props imc_mode_ctrl_props_i (.clk_sys(clk_sys), .rstn(rstn),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .sclOut(sclOut), .sclOen(sclOen), .sdaOut(sdaOut), .sdaOen(sdaOen));

/* File: sim/testbench.sv */
// self-checking bench: register port, master frames, wait state, transmit FIFO
// assumes the partner model resolves both open-drain lines
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic clr = 1'b1;
    logic [7:0] regRdData, rxByte, riseCnt, d;
    logic [15:0] maxPer;
    logic sclOen, sdaOen, sclLine, sdaLine, txReady, eventFlag, busy;
    int errors = 0;
    int cmp_count = 0;
    imc_mode_ctrl imc_mode_ctrl_i (.clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .sclIn(sclLine), .sclOut(), .sclOen(sclOen), .sdaIn(sdaLine), .sdaOut(), .sdaOen(sdaOen),
        .txReady(txReady), .eventFlag(eventFlag), .busy(busy));
    imc_bus_partner imc_bus_partner_i (.clk_sys(clk_sys), .clr(clr), .sclOen(sclOen),
        .sdaOen(sdaOen), .sclLine(sclLine), .sdaLine(sdaLine), .rxByte(rxByte),
        .riseCnt(riseCnt), .maxPer(maxPer));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= v;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1;
        d = regRdData;
    endtask : rd
    // idle=0 stops at the flag even while the engine still runs
    task automatic wait_flag(input logic idle, input int lim);
        int n;
        n = 0;
        while (!(eventFlag === 1'b1 && (busy === 1'b0 || !idle)) && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        chk("flag wait", 16'h0001, 16'(n < lim));
    endtask : wait_flag
    task automatic start(input logic [7:0] m, input logic [7:0] v);
        clr <= 1'b1;
        wr(imc_pkg::ADDR_CTRL, 8'hB0);
        wr(imc_pkg::ADDR_MODE, m);
        clr <= 1'b0;
        wr(imc_pkg::ADDR_DATA, v);
    endtask : start
    task automatic t_regs();
        rd(imc_pkg::ADDR_FMT);
        chk("fmt reset", 16'h0002, d);
        wr(imc_pkg::ADDR_MODE, 8'hF8);
        rd(imc_pkg::ADDR_MODE);
        chk("mode locked", 16'h0000, d);
        wr(imc_pkg::ADDR_CTRL, 8'h80);
        rd(imc_pkg::ADDR_MODE);
        chk("mode reset", 16'h0000, d);
        wr(imc_pkg::ADDR_MODE, 8'hF8);
        rd(imc_pkg::ADDR_MODE);
        chk("mode rw", 16'h00F8, d);
        rd(3'h5);
        chk("unmapped", 16'h0000, d);
        wr(imc_pkg::ADDR_CTRL, 8'h00);
        rd(imc_pkg::ADDR_MODE);
        chk("mode off", 16'h0000, d);
    endtask : t_regs
    task automatic frame(input logic [7:0] m, input logic [7:0] f, input logic [7:0] v,
                         input logic [7:0] bits, input logic [7:0] rx, input logic [15:0] per);
        wr(imc_pkg::ADDR_FMT, f);
        start(m, v);
        wait_flag(1'b1, 3000);
        chk("rises", bits, riseCnt);
        chk("rx byte", rx, rxByte);
        chk("period", per, maxPer);
        rd(imc_pkg::ADDR_MODE);
        chk("count cleared", m & 8'hF8, d);
    endtask : frame
    task automatic t_wait();
        start(8'h40, 8'hC3);
        wait_flag(1'b0, 3000);
        chk("rises at wait", 16'h0008, riseCnt);
        repeat (200) @(posedge clk_sys);
        chk("clock held", 16'h0000, sclLine);
        chk("rises held", 16'h0008, riseCnt);
        rd(imc_pkg::ADDR_STAT);
        chk("status wait", 16'h000B, d);
        wr(imc_pkg::ADDR_CTRL, 8'hB0);
        wait_flag(1'b1, 500);
        chk("rises after", 16'h0009, riseCnt);
    endtask : t_wait
    task automatic t_fifo();
        wr(imc_pkg::ADDR_MODE, 8'h00);
        wr(imc_pkg::ADDR_CTRL, 8'h90);
        clr <= 1'b1;
        repeat (5) wr(imc_pkg::ADDR_DATA, 8'h55);
        clr <= 1'b0;
        rd(imc_pkg::ADDR_STAT);
        chk("status full", 16'h0004, d);
        chk("tx ready", 16'h0000, txReady);
        chk("slave clock", 16'h0001, sclLine);
        wr(imc_pkg::ADDR_CTRL, 8'hB0);
        // four frames of 9 bits at divisor 28, with margin
        repeat (1300) @(posedge clk_sys);
        chk("drained rises", 16'h0024, riseCnt);
        rd(imc_pkg::ADDR_STAT);
        chk("status empty", 16'h0008, d);
    endtask : t_fifo
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_regs();
        frame(8'h00, 8'h02, 8'hA5, 8'h09, 8'hA5, 16'h001C);
        frame(8'hA0, 8'h07, 8'h01, 8'h08, 8'h80, 16'h00A0);
        frame(8'h05, 8'h03, 8'hA8, 8'h05, 8'h15, 16'h001C);
        frame(8'h38, 8'h02, 8'h3C, 8'h09, 8'h3C, 16'h0080);
        t_wait();
        t_fifo();
        end_of_test();
    end
    initial begin
        #400_000;
        errors++;
        end_of_test();
    end
endmodule : testbench
